// >>> inc/cag_pkg.sv
// Function
// - Relative displacement signed, added to next address
// - Relative targets for all conditional and short branches
// - Absolute branch loads 16-bit immediate
// - Table call reads entry at 40H-7FH
// - Register jump loads accumulator pair
// - No branch: advance by instruction length
// - Direct mode uses immediate address unchanged
// - Short direct reaches FE20H to FF1FH only
// - Short direct bit 8 set below 20H
// - Short direct word form uses even addresses
// - Word access to special registers only short
// - Special register page address is FF00H plus byte
// - FF00H-FF1FH special registers use short direct
// - Register fields select byte register or pair
// - Indirect uses pointer or base pair
// - Based adds zero-extended offset, wraps
// - Stack addressing for push and pop
// - Decrement before write, increment after read
// - Table word: low byte even, high odd
package cag_pkg;

  // ==========================================================================
  // Address constants
  localparam logic [15:0] CAG_RESET_VECTOR = 16'h0000;  // Reset vector location
  localparam logic [15:0] CAG_SP_RESET     = 16'h0000;  // Stack pointer after reset
  localparam logic [6:0]  CAG_SHORT_HI     = 7'h7f;     // Upper bits of short window
  localparam logic [7:0]  CAG_SHORT_SPLIT  = 8'h20;     // Below this bit 8 is set
  localparam logic [7:0]  CAG_SFR_PAGE     = 8'hff;     // Special register page
  localparam logic [7:0]  CAG_RAM_PAGE     = 8'hfe;     // High-speed RAM page
  localparam logic [8:0]  CAG_TABLE_HI     = 9'h000;    // Table area upper bits
  localparam logic [15:0] CAG_ONE          = 16'h0001;  // Unit step

  // ==========================================================================
  // Operation codes from the sequencer
  typedef enum logic [3:0] {
    CAG_OP_SEQ, CAG_OP_REL, CAG_OP_ABS, CAG_OP_TBL, CAG_OP_REGJ,
    CAG_OP_DIR, CAG_OP_SHORT, CAG_OP_SFR, CAG_OP_REG, CAG_OP_IND,
    CAG_OP_BASED, CAG_OP_PUSH, CAG_OP_POP, CAG_OP_SPLD
  } cag_op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    CAG_ST_IDLE, CAG_ST_LO, CAG_ST_HI
  } cag_st_t;

  // ==========================================================================
  // Command carried from the instruction decoder
  typedef struct packed {
    cag_op_t     op;       // Requested operation
    logic [2:0]  instLen;  // Bytes of the current instruction
    logic [15:0] imm16;    // Absolute address operand
    logic [7:0]  imm8;     // Displacement, offset or short operand
    logic [7:0]  opcode;   // Opcode byte, table index in bits 5:1
    logic        word;     // Word-sized operand access
  } cag_cmd_t;

  // Register pair values from the register file
  typedef struct packed {
    logic [15:0] accumulatorPair;  // Jump source
    logic [15:0] pointerPair;      // Indirect source 0
    logic [15:0] basePair;         // Indirect source 1 and base
  } cag_regs_t;

  // Effective address result
  typedef struct packed {
    logic [15:0] addr;    // Effective address
    logic        wordOk;  // Word access permitted
    logic        misuse;  // Form not allowed for this address
  } cag_ea_t;

endpackage

// >>> hdl/cag_ea_calc.sv
`timescale 1ns/1ps
module cag_ea_calc (
  input  wire cag_pkg::cag_cmd_t  cmd,   // Decoded command
  input  wire cag_pkg::cag_regs_t regs,  // Register pair values
  input  wire logic [15:0]        sp,    // Current stack pointer
  output cag_pkg::cag_ea_t        ea     // Computed operand address
);

  // ==========================================================================
  // Operand address by mode
  always_comb begin
    logic [15:0] ptr;
    ptr       = cmd.opcode[0] ? regs.basePair : regs.pointerPair;
    ea.addr   = 16'h0000;
    ea.wordOk = 1'b0;
    ea.misuse = 1'b0;
    case (cmd.op)
      cag_pkg::CAG_OP_DIR: begin
        ea.addr = cmd.imm16;
      end
      cag_pkg::CAG_OP_SHORT: begin
        // Window FE20H-FF1FH, bit 8 from operand range
        ea.addr   = {cag_pkg::CAG_SHORT_HI, cmd.imm8 < cag_pkg::CAG_SHORT_SPLIT,
                     cmd.imm8[7:1], cmd.imm8[0] & ~cmd.word};
        ea.wordOk = cmd.word;
      end
      cag_pkg::CAG_OP_SFR: begin
        ea.addr   = {cag_pkg::CAG_SFR_PAGE, cmd.imm8};
        ea.misuse = cmd.word | (cmd.imm8 < cag_pkg::CAG_SHORT_SPLIT);
      end
      cag_pkg::CAG_OP_IND: begin
        ea.addr = ptr;
      end
      cag_pkg::CAG_OP_BASED: begin
        ea.addr = regs.basePair + {8'h00, cmd.imm8};
      end
      cag_pkg::CAG_OP_PUSH: begin
        ea.addr   = sp - cag_pkg::CAG_ONE;
        ea.misuse = ea.addr[15:8] != cag_pkg::CAG_RAM_PAGE;
      end
      cag_pkg::CAG_OP_POP: begin
        ea.addr   = sp;
        ea.misuse = sp[15:8] != cag_pkg::CAG_RAM_PAGE;
      end
      default: begin
        ea.addr = 16'h0000;
      end
    endcase
  end

endmodule // cag_ea_calc

// >>> hdl/cag_addr_gen.sv
`timescale 1ns/1ps
module cag_addr_gen (
  input  wire logic               mclk,          // CPU clock
  input  wire logic               rst_b,         // Asynchronous reset, active low
  input  wire logic               cmdValid,      // Command offered
  input  wire cag_pkg::cag_cmd_t  cmd,           // Command fields
  output logic                    cmdReady,      // Command accepted when valid
  input  wire cag_pkg::cag_regs_t regs,          // Register pair values
  output logic                    memReq,        // Memory byte read request
  output logic [15:0]             memAddr,       // Memory read address
  input  wire logic               memAck,        // Read data present
  input  wire logic [7:0]         memRdData,     // Read data byte
  output logic [15:0]             programCounter,// Program counter
  output logic [15:0]             stackPointer,  // Stack pointer
  output logic                    pcDone,        // Program counter updated pulse
  output logic                    eaValid,       // Effective address pulse
  output logic [15:0]             effAddr,       // Effective address
  output logic                    eaWordOk,      // Word access permitted
  output logic                    eaMisuse,      // Addressing form misuse
  output logic [2:0]              regSel,        // Byte register select
  output logic [1:0]              pairSel        // Register pair select
);

  // ==========================================================================
  // State record
  typedef struct packed {
    cag_pkg::cag_st_t st;      // Sequencer state
    logic [15:0]      pc;      // Program counter
    logic [15:0]      sp;      // Stack pointer
    logic [15:0]      ea;      // Effective address
    logic             wordOk;  // Word access flag
    logic             misuse;  // Misuse flag
    logic             eaV;     // Address valid pulse
    logic             pcV;     // PC done pulse
    logic             req;     // Memory request
    logic [15:0]      mAddr;   // Memory address
    logic [7:0]       lowB;    // Captured low byte
    logic [2:0]       rSel;    // Byte register select
    logic [1:0]       pSel;    // Pair select
  } cag_state_t;

  cag_state_t       cur_ff;     // Registered state
  cag_state_t       nxt_cur;    // Next state
  cag_pkg::cag_ea_t eaCalc;     // Operand address
  logic [15:0]      nextInst;   // Start of following instruction
  logic [15:0]      relTarget;  // Relative branch target
  logic             take;       // Command taken this cycle

  // ==========================================================================
  // Operand address calculator
  cag_ea_calc u_ea (
    .cmd  (cmd),
    .regs (regs),
    .sp   (cur_ff.sp),
    .ea   (eaCalc)
  );

  // ==========================================================================
  // Branch arithmetic, wraps at 16 bits
  always_comb begin
    nextInst  = cur_ff.pc + {13'h0000, cmd.instLen};
    relTarget = nextInst + {{8{cmd.imm8[7]}}, cmd.imm8};
  end

  // Handshake: accept only when idle
  assign cmdReady = cur_ff.st == cag_pkg::CAG_ST_IDLE;
  assign take     = cmdReady & cmdValid;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    nxt_cur     = cur_ff;
    nxt_cur.eaV = 1'b0;
    nxt_cur.pcV = 1'b0;
    case (cur_ff.st)
      cag_pkg::CAG_ST_IDLE: begin
        if (take) begin
          case (cmd.op)
            cag_pkg::CAG_OP_SEQ: begin
              nxt_cur.pc  = nextInst;
              nxt_cur.pcV = 1'b1;
            end
            cag_pkg::CAG_OP_REL: begin
              nxt_cur.pc  = relTarget;
              nxt_cur.pcV = 1'b1;
            end
            cag_pkg::CAG_OP_ABS: begin
              nxt_cur.pc  = cmd.imm16;
              nxt_cur.pcV = 1'b1;
            end
            cag_pkg::CAG_OP_REGJ: begin
              nxt_cur.pc  = regs.accumulatorPair;
              nxt_cur.pcV = 1'b1;
            end
            cag_pkg::CAG_OP_TBL: begin
              // Entry at 40H + 2 * index, low byte first
              nxt_cur.mAddr = {cag_pkg::CAG_TABLE_HI, 1'b1, cmd.opcode[5:1],
                               1'b0};
              nxt_cur.req   = 1'b1;
              nxt_cur.st    = cag_pkg::CAG_ST_LO;
            end
            cag_pkg::CAG_OP_REG: begin
              nxt_cur.rSel = cmd.opcode[2:0];
              nxt_cur.pSel = cmd.opcode[2:1];
              nxt_cur.eaV  = 1'b1;
            end
            cag_pkg::CAG_OP_SPLD: begin
              nxt_cur.sp = cmd.imm16;  // Software initialises the stack
            end
            default: begin
              // Memory operand forms
              nxt_cur.ea     = eaCalc.addr;
              nxt_cur.wordOk = eaCalc.wordOk;
              nxt_cur.misuse = eaCalc.misuse;
              nxt_cur.eaV    = 1'b1;
              if (cmd.op == cag_pkg::CAG_OP_PUSH) begin
                nxt_cur.sp = eaCalc.addr;
              end else if (cmd.op == cag_pkg::CAG_OP_POP) begin
                nxt_cur.sp = cur_ff.sp + cag_pkg::CAG_ONE;
              end
            end
          endcase
        end
      end
      cag_pkg::CAG_ST_LO: begin
        // Low byte from even address
        if (memAck) begin
          nxt_cur.lowB  = memRdData;
          nxt_cur.mAddr = cur_ff.mAddr | cag_pkg::CAG_ONE;
          nxt_cur.st    = cag_pkg::CAG_ST_HI;
        end
      end
      cag_pkg::CAG_ST_HI: begin
        // High byte from odd address, then load the counter
        if (memAck) begin
          nxt_cur.pc  = {memRdData, cur_ff.lowB};
          nxt_cur.pcV = 1'b1;
          nxt_cur.req = 1'b0;
          nxt_cur.st  = cag_pkg::CAG_ST_IDLE;
        end
      end
      default: begin
        nxt_cur.st  = cag_pkg::CAG_ST_IDLE;
        nxt_cur.req = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // State register; reset fetches the reset vector
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff        <= '0;
      cur_ff.st     <= cag_pkg::CAG_ST_LO;
      cur_ff.req    <= 1'b1;
      cur_ff.mAddr  <= cag_pkg::CAG_RESET_VECTOR;
      cur_ff.pc     <= cag_pkg::CAG_RESET_VECTOR;
      cur_ff.sp     <= cag_pkg::CAG_SP_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ==========================================================================
  // Outputs from the state record
  assign memReq         = cur_ff.req;
  assign memAddr        = cur_ff.mAddr;
  assign programCounter = cur_ff.pc;
  assign stackPointer   = cur_ff.sp;
  assign pcDone         = cur_ff.pcV;
  assign eaValid        = cur_ff.eaV;
  assign effAddr        = cur_ff.ea;
  assign eaWordOk       = cur_ff.wordOk;
  assign eaMisuse       = cur_ff.misuse;
  assign regSel         = cur_ff.rSel;
  assign pairSel        = cur_ff.pSel;

endmodule // cag_addr_gen

// >>> tb/cag_mem_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Program memory model answering byte reads, quickly or after three waits
module cag_mem_model (
  input  wire logic        mclk,      // CPU clock
  input  wire logic        rst_b,     // Reset, active low
  input  wire logic        slow,      // Stretch each answer
  input  wire logic        memReq,    // Read pending
  input  wire logic [15:0] memAddr,   // Read address
  output logic             memAck,    // Read answered
  output logic [7:0]       memRdData  // Read byte
);
  logic [1:0] waitCnt;  // Cycles waited on this read
  // Byte at an address is its low byte plus 11h; data toggles when not answering
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      memAck    <= 1'b0;
      memRdData <= 8'h00;
      waitCnt   <= 2'h0;
    end else if (memAck || !memReq || (slow && waitCnt != 2'h3)) begin
      memAck    <= 1'b0;
      memRdData <= ~memRdData;
      waitCnt   <= (memAck || !memReq) ? 2'h0 : waitCnt + 2'h1;
    end else begin
      memAck    <= 1'b1;  // One byte per answer at its own address
      memRdData <= memAddr[7:0] + 8'h11;
    end
  end
endmodule // cag_mem_model

// >>> tb/cag_addr_gen_chk.sv
`timescale 1ns/1ps
// ==========================================================================
// Checker on the address generator ports
module cag_addr_gen_chk (
  input wire logic               mclk,           // CPU clock
  input wire logic               rst_b,          // Reset, active low
  input wire logic               cmdValid,       // Command offered
  input wire cag_pkg::cag_cmd_t  cmd,            // Command fields
  input wire logic               cmdReady,       // Command accepted
  input wire cag_pkg::cag_regs_t regs,           // Register pairs
  input wire logic               memReq,         // Read pending
  input wire logic [15:0]        memAddr,        // Read address
  input wire logic [15:0]        programCounter, // Program counter
  input wire logic [15:0]        stackPointer,   // Stack pointer
  input wire logic               pcDone,         // Counter updated
  input wire logic [15:0]        effAddr,        // Effective address
  input wire logic               eaWordOk,       // Word access allowed
  input wire logic               eaMisuse        // Form misused
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire take = cmdValid && cmdReady;  // Command taken at this edge
  // Table call taken, then its entry read in the table area
  sequence s_tbl_take;
    take && cmd.op == cag_pkg::CAG_OP_TBL;
  endsequence
  sequence s_tbl_read;
    memReq && memAddr == {9'h000, 1'b1, $past(cmd.opcode[5:1]), 1'b0};
  endsequence
  a_rel_target: assert property (
    take && cmd.op == cag_pkg::CAG_OP_REL |=> pcDone && programCounter == $past(programCounter)
      + {13'h0, $past(cmd.instLen)} + {{8{$past(cmd.imm8[7])}}, $past(cmd.imm8)})
    else $error("relative target wrong");
  a_abs_target: assert property (
    take && cmd.op == cag_pkg::CAG_OP_ABS |=> pcDone && programCounter == $past(cmd.imm16))
    else $error("absolute target wrong");
  a_seq_advance: assert property (
    take && cmd.op == cag_pkg::CAG_OP_SEQ |=>
      programCounter == $past(programCounter) + {13'h0, $past(cmd.instLen)})
    else $error("sequential advance wrong");
  a_tbl_entry: assert property (s_tbl_take |=> s_tbl_read)
    else $error("table entry address wrong");
  a_short_ea: assert property (
    take && cmd.op == cag_pkg::CAG_OP_SHORT |=> eaWordOk == $past(cmd.word) && effAddr ==
      {7'h7f, $past(cmd.imm8) < 8'h20, $past(cmd.imm8[7:1]), $past(cmd.imm8[0] & !cmd.word)})
    else $error("short direct address wrong");
  a_sfr_ea: assert property (
    take && cmd.op == cag_pkg::CAG_OP_SFR |=> effAddr == {8'hff, $past(cmd.imm8)}
      && eaMisuse == $past(cmd.word || cmd.imm8 < 8'h20))
    else $error("register page address wrong");
  a_based_wrap: assert property (
    take && cmd.op == cag_pkg::CAG_OP_BASED |=>
      effAddr == $past(regs.basePair) + {8'h00, $past(cmd.imm8)})
    else $error("based address wrong");
  a_stack_push: assert property (
    take && cmd.op == cag_pkg::CAG_OP_PUSH |=>
      effAddr == $past(stackPointer) - 16'h0001 && stackPointer == effAddr)
    else $error("push address wrong");
endmodule // cag_addr_gen_chk
bind cag_addr_gen cag_addr_gen_chk i_cag_addr_gen_chk (.mclk, .rst_b, .cmdValid, .cmd,
  .cmdReady, .regs, .memReq, .memAddr, .programCounter, .stackPointer, .pcDone, .effAddr,
  .eaWordOk, .eaMisuse);

// >>> tb/cag_addr_gen_bench.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench for the address generator
module cag_addr_gen_bench;
  logic               mclk = 1'b0;      // CPU clock
  logic               rst_b = 1'b0;     // Reset, active low
  logic               cmdValid = 1'b0;  // Command offered
  logic               slow = 1'b0;      // Slow memory answers
  cag_pkg::cag_cmd_t  cmd = '0;         // Command fields
  cag_pkg::cag_regs_t regs = {16'h1234, 16'h4567, 16'hffff};  // Jump, pointer, base
  logic               cmdReady, memReq, memAck, pcDone, eaValid, eaWordOk, eaMisuse;
  logic [15:0]        memAddr, programCounter, stackPointer, effAddr;  // Addresses
  logic [7:0]         memRdData;        // Read byte
  logic [2:0]         regSel;           // Byte register select
  logic [1:0]         pairSel;          // Pair select
  int                 mismatches = 0, nCompared = 0, cycles = 0;  // Counters
  always #20 mclk = ~mclk;
  cag_addr_gen i_cag_addr_gen (.mclk, .rst_b, .cmdValid, .cmd, .cmdReady, .regs, .memReq,
    .memAddr, .memAck, .memRdData, .programCounter, .stackPointer, .pcDone, .eaValid,
    .effAddr, .eaWordOk, .eaMisuse, .regSel, .pairSel);
  cag_mem_model i_cag_mem_model (.mclk, .rst_b, .slow, .memReq, .memAddr, .memAck, .memRdData);
  // Cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("mismatches %0d compared %0d", mismatches, nCompared);
    if (mismatches == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Offer a command, hold it until taken, then wait for its answer
  task automatic run(input cag_pkg::cag_op_t op, input logic [2:0] len,
                     input logic [15:0] i16, input logic [7:0] i8, input logic w);
    @(posedge mclk);
    cmd      <= '{op, len, i16, i8, i8, w};
    cmdValid <= 1'b1;
    #1;
    while (cmdReady !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    cmdValid <= 1'b0;
    #1;
    while (op != cag_pkg::CAG_OP_SPLD && pcDone !== 1'b1 && eaValid !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic pc_case(input cag_pkg::cag_op_t op, input logic [2:0] len,
                         input logic [15:0] i16, input logic [7:0] i8, input logic [15:0] exp);
    run(op, len, i16, i8, 1'b0);
    chk(programCounter, exp);
  endtask
  task automatic ea_case(input cag_pkg::cag_op_t op, input logic [7:0] i8, input logic w,
                         input logic [15:0] exp);
    run(op, 3'h2, 16'ha5c3, i8, w);
    chk(effAddr, exp);
  endtask
  task automatic t_branches;
    pc_case(cag_pkg::CAG_OP_ABS, 3'h3, 16'hfffe, 8'h00, 16'hfffe);
    pc_case(cag_pkg::CAG_OP_SEQ, 3'h3, 16'h0000, 8'h00, 16'h0001);
    pc_case(cag_pkg::CAG_OP_REL, 3'h2, 16'h0000, 8'h80, 16'hff83);
    pc_case(cag_pkg::CAG_OP_REL, 3'h2, 16'h0000, 8'h7f, 16'h0004);
    pc_case(cag_pkg::CAG_OP_REGJ, 3'h1, 16'h0000, 8'h00, 16'h1234);
  endtask
  task automatic t_table;
    @(posedge mclk);
    slow <= 1'b1;
    pc_case(cag_pkg::CAG_OP_TBL, 3'h1, 16'h0000, 8'h3e, 16'h908f);
    @(posedge mclk);
    slow <= 1'b0;
    pc_case(cag_pkg::CAG_OP_TBL, 3'h1, 16'h0000, 8'h01, 16'h5251);
  endtask
  task automatic t_operands;
    ea_case(cag_pkg::CAG_OP_DIR, 8'h00, 1'b0, 16'ha5c3);
    ea_case(cag_pkg::CAG_OP_SHORT, 8'h1f, 1'b0, 16'hff1f);
    ea_case(cag_pkg::CAG_OP_SHORT, 8'h20, 1'b0, 16'hfe20);
    ea_case(cag_pkg::CAG_OP_SHORT, 8'h21, 1'b1, 16'hfe20);
    chk({15'h0, eaWordOk}, 16'h0001);
    ea_case(cag_pkg::CAG_OP_SFR, 8'h20, 1'b0, 16'hff20);
    chk({15'h0, eaMisuse}, 16'h0000);
    ea_case(cag_pkg::CAG_OP_SFR, 8'h1f, 1'b0, 16'hff1f);
    chk({15'h0, eaMisuse}, 16'h0001);
    ea_case(cag_pkg::CAG_OP_IND, 8'h00, 1'b0, 16'h4567);
    ea_case(cag_pkg::CAG_OP_IND, 8'h01, 1'b0, 16'hffff);
    ea_case(cag_pkg::CAG_OP_BASED, 8'hff, 1'b0, 16'h00fe);
    run(cag_pkg::CAG_OP_REG, 3'h1, 16'h0000, 8'h05, 1'b0);
    chk({13'h0, regSel}, 16'h0005);
    chk({14'h0, pairSel}, 16'h0002);
  endtask
  task automatic t_stack;
    run(cag_pkg::CAG_OP_SPLD, 3'h3, 16'hfe80, 8'h00, 1'b0);
    ea_case(cag_pkg::CAG_OP_PUSH, 8'h00, 1'b0, 16'hfe7f);
    chk(stackPointer, 16'hfe7f);
    ea_case(cag_pkg::CAG_OP_POP, 8'h00, 1'b0, 16'hfe7f);
    chk(stackPointer, 16'hfe80);
  endtask
  // Reset, fetch the start vector, then each group of operations
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    while (pcDone !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
    chk(programCounter, 16'h1211);
    t_branches();
    t_table();
    t_operands();
    t_stack();
    print_verdict();
  end
endmodule // cag_addr_gen_bench
